// ---- verilog/mbs_pkg.sv ----
// Shared constants, types and helpers of the serial slave readout
package mbs_pkg;

  // ********************************
  // Timing and line rates
  // ********************************
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned RESP_TIME_MS = 1000;
  localparam int unsigned BAUD_TABLE [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  localparam logic [7:0] CHAR_BITS = 8'h0b;
  localparam logic [3:0] FRAME_BITS_NOPAR = 4'ha;
  localparam logic [3:0] FRAME_BITS_PAR = 4'hb;

  // ********************************
  // Configuration codes, defaults and address limits
  // ********************************
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [2:0] DEF_BAUD_SEL = 3'h4;
  localparam logic [1:0] DEF_PARITY = PAR_NONE;
  localparam logic DEF_ASCII = 1'b0;
  localparam logic [7:0] DEF_DELAY_MS = 8'h00;
  localparam logic [3:0] DEF_IFS_CHARS = 4'h7;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hfb;

  // ********************************
  // Protocol codes and register map
  // ********************************
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VAL = 8'h03;
  localparam logic [15:0] MAX_QTY = 16'h007d;
  localparam logic [16:0] REG_SPAN = 17'h00026;
  localparam logic [15:0] REG_BASE [6] = '{16'h0000, 16'h0006, 16'h000c, 16'h0012, 16'h0018, 16'h0024};
  localparam logic [3:0] RTU_REQ_LEN = 4'h8;
  localparam logic [3:0] ASC_REQ_LEN = 4'h7;
  localparam logic [7:0] HDR_LEN = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] ASC_COLON = 8'h3a;
  localparam logic [7:0] ASC_CR = 8'h0d;
  localparam logic [7:0] ASC_LF = 8'h0a;
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] ASC_NINE = 8'h39;
  localparam logic [7:0] ASC_UA = 8'h41;
  localparam logic [7:0] ASC_UF = 8'h46;
  localparam logic [7:0] ASC_ALPHA_OFS = 8'h37;

  typedef enum logic [3:0] {
    ST_RX = 4'b0001, ST_EVAL = 4'b0010, ST_DELAY = 4'b0100, ST_SEND = 4'b1000
  } mbs_state_t;

  typedef enum logic [3:0] {
    TP_HEAD = 4'b0001, TP_BODY = 4'b0010, TP_CHK = 4'b0100, TP_TAIL = 4'b1000
  } mbs_phase_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    return (v < 4'ha) ? 8'(ASC_ZERO + {4'h0, v}) : 8'(ASC_ALPHA_OFS + {4'h0, v});
  endfunction

  // Upper bit flags a legal digit; lower case is not accepted
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= ASC_ZERO && c <= ASC_NINE) begin
      d = 8'(c - ASC_ZERO);
    end else if (c >= ASC_UA && c <= ASC_UF) begin
      d = 8'(c - ASC_ALPHA_OFS);
    end
    return {(c >= ASC_ZERO && c <= ASC_NINE) || (c >= ASC_UA && c <= ASC_UF), d[3:0]};
  endfunction

endpackage

// ---- verilog/mbs_uart_if.sv ----
// Byte-level link between the frame engine and the serial shifter
interface mbs_uart_if;
  logic [19:0] divisor;
  logic [1:0] parity;
  logic bit_tick;
  logic rx_valid;
  logic rx_err;
  logic rx_busy;
  logic [7:0] rx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  modport ctl (output divisor, parity, tx_valid, tx_data,
               input bit_tick, rx_valid, rx_err, rx_busy, rx_data, tx_ready);
  modport phy (input divisor, parity, tx_valid, tx_data,
               output bit_tick, rx_valid, rx_err, rx_busy, rx_data, tx_ready);
endinterface

// ---- verilog/mbs_uart.sv ----
// Serial shifter: one start bit, eight data bits, optional parity, one stop bit
module mbs_uart
  import mbs_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic rx_in,
  output logic tx_out,
  mbs_uart_if.phy u
);

  typedef struct packed {
    logic [19:0] tick_cnt;
    logic tick;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [19:0] tx_div;
    logic line;
    logic rx_act;
    logic [19:0] rx_div;
    logic [3:0] rx_idx;
    logic [9:0] rx_sh;
    logic rx_valid;
    logic rx_err;
    logic [7:0] rx_data;
  } mbs_uart_st_t;

  localparam mbs_uart_st_t UART_RST = '{line: 1'b1, default: '0};

  mbs_uart_st_t uart_reg;
  mbs_uart_st_t uart_next;
  logic par_on;
  logic [9:0] s;

  assign par_on = (u.parity != PAR_NONE);
  assign tx_out = uart_reg.line;
  assign u.bit_tick = uart_reg.tick;
  assign u.rx_valid = uart_reg.rx_valid;
  assign u.rx_err = uart_reg.rx_err;
  assign u.rx_data = uart_reg.rx_data;
  assign u.rx_busy = uart_reg.rx_act;
  assign u.tx_ready = (uart_reg.tx_left == 4'h0);

  always_comb begin
    uart_next = uart_reg;
    uart_next.tick = 1'b0;
    uart_next.rx_valid = 1'b0;
    s = {rx_in, uart_reg.rx_sh[9:1]};
    // ********************************
    // Free bit-time tick for silence timing
    // ********************************
    if (uart_reg.tick_cnt >= 20'(u.divisor - 20'h1)) begin
      uart_next.tick_cnt = 20'h0;
      uart_next.tick = 1'b1;
    end else begin
      uart_next.tick_cnt = 20'(uart_reg.tick_cnt + 20'h1);
    end
    // ********************************
    // Transmit
    // ********************************
    if (uart_reg.tx_left == 4'h0) begin
      if (u.tx_valid) begin
        uart_next.tx_sh = par_on ? {1'b1, (u.parity == PAR_ODD) ^ (^u.tx_data), u.tx_data, 1'b0}
                                 : {2'b11, u.tx_data, 1'b0};
        uart_next.tx_left = par_on ? FRAME_BITS_PAR : FRAME_BITS_NOPAR;
        uart_next.tx_div = 20'h0;
      end
    end else if (uart_reg.tx_div >= 20'(u.divisor - 20'h1)) begin
      uart_next.tx_div = 20'h0;
      uart_next.tx_sh = {1'b1, uart_reg.tx_sh[10:1]};
      uart_next.tx_left = 4'(uart_reg.tx_left - 4'h1);
    end else begin
      uart_next.tx_div = 20'(uart_reg.tx_div + 20'h1);
    end
    uart_next.line = (uart_next.tx_left != 4'h0) ? uart_next.tx_sh[0] : 1'b1;
    // ********************************
    // Receive, sampled mid-bit
    // ********************************
    if (!uart_reg.rx_act) begin
      if (!rx_in) begin
        uart_next.rx_act = 1'b1;
        uart_next.rx_div = u.divisor >> 1;
        uart_next.rx_idx = 4'h0;
      end
    end else if (uart_reg.rx_div != 20'h0) begin
      uart_next.rx_div = 20'(uart_reg.rx_div - 20'h1);
    end else begin
      uart_next.rx_div = 20'(u.divisor - 20'h1);
      uart_next.rx_idx = 4'(uart_reg.rx_idx + 4'h1);
      if (uart_reg.rx_idx == 4'h0) begin
        // Glitch shorter than half a bit is not a start
        uart_next.rx_act = !rx_in;
      end else begin
        uart_next.rx_sh = s;
        if (uart_reg.rx_idx == (par_on ? FRAME_BITS_NOPAR : 4'(FRAME_BITS_NOPAR - 4'h1))) begin
          uart_next.rx_act = 1'b0;
          uart_next.rx_valid = 1'b1;
          uart_next.rx_data = par_on ? s[7:0] : s[8:1];
          uart_next.rx_err = !s[9] || (par_on && (s[8] != ((u.parity == PAR_ODD) ^ (^s[7:0]))));
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      uart_reg <= UART_RST;
    end else begin
      uart_reg <= uart_next;
    end
  end

endmodule

// ---- verilog/mbs_slave.sv ----
// Serial bus slave that answers holding-register reads of six measurement channels
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLOCK_HZ
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic rx_in,
  output logic tx_out,
  output logic de_out,
  input wire logic cfg_custom_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [2:0] cfg_baud_sel_in,
  input wire logic [1:0] cfg_parity_in,
  input wire logic cfg_ascii_in,
  input wire logic [7:0] cfg_delay_ms_in,
  input wire logic [3:0] cfg_ifs_chars_in,
  input wire logic [6:0] serial_digits_in,
  input wire logic [31:0] velocity_value_in,
  input wire logic [31:0] flow_value_in,
  input wire logic [31:0] forward_total_in,
  input wire logic [31:0] reverse_total_in,
  input wire logic [31:0] medium_temperature_value_in,
  input wire logic [31:0] ambient_temperature_value_in
);
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    mbs_state_t state;
    mbs_phase_t phase;
    logic [7:0][7:0] rx_buf;
    logic [3:0] rx_cnt;
    logic rx_bad;
    logic asc_act;
    logic asc_half;
    logic [3:0] asc_hi;
    logic [15:0] crc;
    logic [7:0] lrc;
    logic [7:0] silence;
    logic [19:0] ms_div;
    logic ms_tick;
    logic [9:0] ms_cnt;
    logic [7:0] exc;
    logic [15:0] start;
    logic [7:0] len;
    logic [7:0] pos;
    logic nib;
    logic fin;
    logic [5:0][31:0] snap;
    logic de;
  } mbs_slave_st_t;
  localparam mbs_slave_st_t SLV_RST = '{state: ST_RX, phase: TP_HEAD, crc: CRC_INIT, default: '0};
  localparam logic [19:0] MS_CYC = 20'(CLK_HZ / MS_PER_S);
  localparam logic [9:0] RESP_TIMEOUT = 10'(RESP_TIME_MS - 1);
  mbs_slave_st_t slv_reg;
  mbs_slave_st_t slv_next;
  mbs_uart_if u_if ();
  logic [7:0] my_addr;
  logic ascii;
  logic [7:0] delay_ms;
  logic [7:0] gap_bits;
  logic [15:0] qty16;
  logic [16:0] last_word;
  logic [7:0] b;
  logic [7:0] l;
  logic [7:0] ch;
  logic [4:0] hv;
  logic [7:0] asc_byte;
  mbs_uart u_uart (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .rx_in(rx_in),
    .tx_out(tx_out),
    .u(u_if.phy)
  );
  function automatic logic [19:0] baud_div(input logic [2:0] sel);
    logic [19:0] d;
    d = 20'h1;
    for (int i = 0; i < 8; i++) begin
      if (sel == 3'(i)) begin
        d = 20'(CLK_HZ / BAUD_TABLE[i]);
      end
    end
    return d;
  endfunction
  // Rearms the receiver after every frame and every answer
  function automatic mbs_slave_st_t rx_clear(input mbs_slave_st_t s);
    mbs_slave_st_t t;
    t = s;
    t.rx_cnt = 4'h0;
    t.rx_bad = 1'b0;
    t.asc_act = 1'b0;
    t.asc_half = 1'b0;
    t.crc = CRC_INIT;
    t.lrc = 8'h00;
    t.silence = 8'h00;
    t.ms_cnt = 10'h0;
    t.ms_div = 20'h0;
    t.ms_tick = 1'b0;
    return t;
  endfunction
  function automatic logic [7:0] resp_byte(input mbs_slave_st_t s);
    logic [7:0] k;
    logic [15:0] w;
    logic [15:0] v;
    k = 8'(s.pos - HDR_LEN);
    w = 16'(s.start + {9'h000, k[7:1]});
    v = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      if (w == REG_BASE[i]) begin
        v = s.snap[i][15:0];
      end
      if (w == 16'(REG_BASE[i] + 16'h1)) begin
        v = s.snap[i][31:16];
      end
    end
    unique case (s.pos)
      8'h00: return s.rx_buf[0];
      8'h01: return (s.exc != EXC_NONE) ? (s.rx_buf[1] | EXC_FLAG) : s.rx_buf[1];
      8'h02: return (s.exc != EXC_NONE) ? s.exc : {s.rx_buf[5][6:0], 1'b0};
      default: return k[0] ? v[7:0] : v[15:8];
    endcase
  endfunction
  // ********************************
  // Effective configuration
  // ********************************
  // defaults out of configuration
  assign ascii = cfg_custom_in ? cfg_ascii_in : DEF_ASCII;
  assign delay_ms = cfg_custom_in ? cfg_delay_ms_in : DEF_DELAY_MS;
  assign gap_bits = 8'({4'h0, cfg_custom_in ? cfg_ifs_chars_in : DEF_IFS_CHARS} * CHAR_BITS);
  assign u_if.divisor = baud_div(cfg_custom_in ? cfg_baud_sel_in : DEF_BAUD_SEL);
  assign u_if.parity = cfg_custom_in ? cfg_parity_in : DEF_PARITY;
  assign my_addr = (cfg_custom_in && cfg_addr_in >= ADDR_MIN && cfg_addr_in <= ADDR_MAX) ? cfg_addr_in
                   : {1'b0, serial_digits_in};
  assign de_out = slv_reg.de;
  assign qty16 = {slv_reg.rx_buf[4], slv_reg.rx_buf[5]};
  assign last_word = 17'({1'b0, slv_reg.rx_buf[2], slv_reg.rx_buf[3]} + {1'b0, qty16});
  assign b = resp_byte(slv_reg);
  assign l = 8'(~slv_reg.lrc + 8'h01);
  assign hv = hex_val(u_if.rx_data);
  assign asc_byte = {slv_reg.asc_hi, hv[3:0]};
  always_comb begin
    slv_next = slv_reg;
    slv_next.ms_tick = 1'b0;
    // ********************************
    // Millisecond tick
    // ********************************
    if (slv_reg.ms_div >= 20'(MS_CYC - 20'h1)) begin
      slv_next.ms_div = 20'h0;
      slv_next.ms_tick = 1'b1;
    end else begin
      slv_next.ms_div = 20'(slv_reg.ms_div + 20'h1);
    end
    unique case (slv_reg.phase)
      TP_HEAD: ch = ASC_COLON;
      TP_BODY: ch = ascii ? hex_char(slv_reg.nib ? b[3:0] : b[7:4]) : b;
      TP_CHK: ch = ascii ? hex_char(slv_reg.nib ? l[3:0] : l[7:4])
                         : (slv_reg.nib ? slv_reg.crc[15:8] : slv_reg.crc[7:0]);
      TP_TAIL: ch = slv_reg.nib ? ASC_LF : ASC_CR;
      default: ch = 8'h00;
    endcase
    u_if.tx_data = ch;
    u_if.tx_valid = (slv_reg.state == ST_SEND) && !slv_reg.fin;
    // ********************************
    // Frame engine
    // ********************************
    unique case (slv_reg.state)
      ST_RX: begin
        if (!ascii) begin
          // RTU: frame ends after the configured silence
          if (u_if.rx_valid) begin
            if (slv_reg.rx_cnt < RTU_REQ_LEN) begin
              slv_next.rx_buf[slv_reg.rx_cnt[2:0]] = u_if.rx_data;
              slv_next.rx_cnt = 4'(slv_reg.rx_cnt + 4'h1);
            end else begin
              slv_next.rx_bad = 1'b1;
            end
            slv_next.rx_bad = slv_next.rx_bad | u_if.rx_err;
            slv_next.crc = crc_step(slv_reg.crc, u_if.rx_data);
            slv_next.silence = 8'h00;
          end else if (u_if.rx_busy) begin
            slv_next.silence = 8'h00;
          end else if (u_if.bit_tick && slv_reg.rx_cnt != 4'h0) begin
            slv_next.silence = 8'(slv_reg.silence + 8'h01);
            if (slv_next.silence >= gap_bits) begin
              slv_next = rx_clear(slv_reg);
              // Residue of zero means the check bytes matched
              if (slv_reg.rx_cnt == RTU_REQ_LEN && !slv_reg.rx_bad && slv_reg.crc == 16'h0000) begin
                slv_next.state = ST_EVAL;
              end
            end
          end
        end else if (u_if.rx_valid) begin
          // ASCII: colon opens, hex pairs, line feed closes
          slv_next.ms_cnt = 10'h0;
          if (u_if.rx_data == ASC_COLON) begin
            slv_next = rx_clear(slv_reg);
            slv_next.asc_act = 1'b1;
            slv_next.rx_bad = u_if.rx_err;
          end else if (slv_reg.asc_act) begin
            slv_next.rx_bad = slv_reg.rx_bad | u_if.rx_err;
            if (u_if.rx_data == ASC_LF) begin
              slv_next = rx_clear(slv_reg);
              if (slv_reg.rx_cnt == ASC_REQ_LEN && !slv_reg.rx_bad && !u_if.rx_err
                  && slv_reg.lrc == 8'h00 && !slv_reg.asc_half) begin
                slv_next.state = ST_EVAL;
              end
            end else if (u_if.rx_data != ASC_CR) begin
              if (!hv[4]) begin
                slv_next.rx_bad = 1'b1;
              end else if (!slv_reg.asc_half) begin
                slv_next.asc_hi = hv[3:0];
                slv_next.asc_half = 1'b1;
              end else begin
                slv_next.asc_half = 1'b0;
                slv_next.lrc = 8'(slv_reg.lrc + asc_byte);
                if (slv_reg.rx_cnt < ASC_REQ_LEN) begin
                  slv_next.rx_buf[slv_reg.rx_cnt[2:0]] = asc_byte;
                  slv_next.rx_cnt = 4'(slv_reg.rx_cnt + 4'h1);
                end else begin
                  slv_next.rx_bad = 1'b1;
                end
              end
            end
          end
        end else if (slv_reg.asc_act && slv_reg.ms_tick) begin
          // stalled frame dropped after response time
          slv_next.ms_cnt = 10'(slv_reg.ms_cnt + 10'h1);
          if (slv_reg.ms_cnt >= RESP_TIMEOUT) begin
            slv_next = rx_clear(slv_reg);
          end
        end
      end
      ST_EVAL: begin
        if (slv_reg.rx_buf[0] != my_addr) begin
          slv_next.state = ST_RX;
        end else begin
          slv_next.start = {slv_reg.rx_buf[2], slv_reg.rx_buf[3]};
          if (slv_reg.rx_buf[1] != FC_READ_HOLD) begin
            slv_next.exc = EXC_ILL_FUNC;
          end else if (qty16 == 16'h0000 || qty16 > MAX_QTY) begin
            slv_next.exc = EXC_ILL_VAL;
          end else if (last_word > REG_SPAN) begin
            slv_next.exc = EXC_ILL_ADDR;
          end else begin
            slv_next.exc = EXC_NONE;
          end
          slv_next.len = (slv_next.exc != EXC_NONE) ? HDR_LEN
                         : 8'(HDR_LEN + {slv_reg.rx_buf[5][6:0], 1'b0});
          slv_next.snap = {ambient_temperature_value_in, medium_temperature_value_in, reverse_total_in,
                           forward_total_in, flow_value_in, velocity_value_in};
          slv_next.pos = 8'h00;
          slv_next.nib = 1'b0;
          slv_next.fin = 1'b0;
          slv_next.state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (slv_reg.ms_cnt >= {2'b00, delay_ms}) begin
          slv_next.state = ST_SEND;
          slv_next.phase = ascii ? TP_HEAD : TP_BODY;
          slv_next.de = 1'b1;
        end else if (slv_reg.ms_tick) begin
          slv_next.ms_cnt = 10'(slv_reg.ms_cnt + 10'h1);
        end
      end
      ST_SEND: begin
        if (slv_reg.fin) begin
          // Driver released only after the last stop bit
          if (u_if.tx_ready) begin
            slv_next = rx_clear(slv_reg);
            slv_next.de = 1'b0;
            slv_next.state = ST_RX;
          end
        end else if (u_if.tx_ready) begin
          unique case (slv_reg.phase)
            TP_HEAD: slv_next.phase = TP_BODY;
            TP_BODY: begin
              if (ascii && !slv_reg.nib) begin
                slv_next.nib = 1'b1;
              end else begin
                slv_next.nib = 1'b0;
                slv_next.crc = crc_step(slv_reg.crc, b);
                slv_next.lrc = 8'(slv_reg.lrc + b);
                slv_next.pos = 8'(slv_reg.pos + 8'h01);
                if (slv_reg.pos == 8'(slv_reg.len - 8'h01)) begin
                  slv_next.phase = TP_CHK;
                end
              end
            end
            TP_CHK: begin
              slv_next.nib = !slv_reg.nib;
              if (slv_reg.nib) begin
                slv_next.phase = ascii ? TP_TAIL : TP_CHK;
                slv_next.fin = !ascii;
              end
            end
            TP_TAIL: begin
              slv_next.nib = !slv_reg.nib;
              slv_next.fin = slv_reg.nib;
            end
            default: slv_next.phase = TP_HEAD;
          endcase
        end
      end
      default: slv_next = SLV_RST;
    endcase
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slv_reg <= SLV_RST;
    end else begin
      slv_reg <= slv_next;
    end
  end

endmodule

// ---- verif/mbs_slave_monitor.sv ----
// Port checker for the serial slave readout
module mbs_slave_monitor
  import mbs_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLOCK_HZ
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic rx_in,
  input wire logic tx_out,
  input wire logic de_out,
  input wire logic cfg_custom_in,
  input wire logic [2:0] cfg_baud_sel_in,
  input wire logic [7:0] cfg_delay_ms_in,
  input wire logic [3:0] cfg_ifs_chars_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Line counters
  // ****************
  int unsigned idle_cnt, de_cnt, div, ms, gap;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_cnt <= 0;
      de_cnt <= 0;
    end else begin
      idle_cnt <= rx_in ? idle_cnt + 1 : 0;
      de_cnt <= de_out ? de_cnt + 1 : 0;
    end
  end
  // Bounds follow live config, so config must not move mid-answer
  always_comb begin
    div = CLK_HZ / BAUD_TABLE[cfg_custom_in ? cfg_baud_sel_in : DEF_BAUD_SEL];
    ms = CLK_HZ / MS_PER_S;
    gap = 32'(cfg_custom_in ? cfg_ifs_chars_in : DEF_IFS_CHARS) * 11 * div;
    gap = gap + 32'(cfg_custom_in ? cfg_delay_ms_in : DEF_DELAY_MS) * ms;
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence s_start_bit;
    ##1 (!tx_out) [*8];
  endsequence
  a_quiet_line_idle: assert property (!de_out |-> tx_out)
    else $error("tx line not idle while driver off");
  a_reset_release: assert property ($rose(nrst_in) |-> tx_out && !de_out)
    else $error("line active right after reset");
  a_answer_start_bit: assert property ($rose(de_out) |-> s_start_bit)
    else $error("answer lacks start bit");
  // Free bit tick may end the gap up to one bit early
  a_default_gap: assert property ($rose(de_out) && !cfg_custom_in |->
    idle_cnt + div >= gap && idle_cnt <= gap + 24 * div)
    else $error("default frame gap wrong");
  a_delay_gap: assert property ($rose(de_out) && cfg_custom_in |->
    idle_cnt + div >= gap && idle_cnt <= gap + 24 * div + ms)
    else $error("answer delay wrong");
  a_driver_hold: assert property ($rose(de_out) |-> de_out [*8])
    else $error("driver enable glitch");
  a_answer_min_len: assert property ($fell(de_out) |-> de_cnt >= 50 * div)
    else $error("answer too short");
  a_answer_max_len: assert property (de_cnt <= 255 * 11 * div)
    else $error("answer too long");
endmodule

bind mbs_slave mbs_slave_monitor #(.CLK_HZ(CLK_HZ)) mon_u (.clock_in, .nrst_in, .rx_in, .tx_out, .de_out,
  .cfg_custom_in, .cfg_baud_sel_in, .cfg_delay_ms_in, .cfg_ifs_chars_in);

// ---- verif/mbs_master_model.sv ----
// Bus master model that frames requests and collects answers
module mbs_master_model (
  input wire logic clock_in,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 52;
  logic [7:0] rxq[$];
  initial line_out = 1'b1;
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  // host reorders to its own byte order
  function automatic logic [31:0] be32(input logic [7:0] b1, b0, b3, b2, input bit lsb);
    return lsb ? {b0, b1, b2, b3} : {b3, b2, b1, b0};
  endfunction
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (div) @(posedge clock_in);
    end
  endtask
  task automatic send(input logic [7:0] b[$], input bit bad);
    logic [15:0] c;
    c = crc16(b) ^ {15'h0, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) put(b[i]);
  endtask
  // Gives up on a missing byte instead of hanging
  task automatic recv(input int n);
    logic [7:0] v;
    rxq.delete();
    for (int k = 0; k < n; k++) begin
      for (int w = 0; w < 40000 && line_in !== 1'b0; w++)
        @(posedge clock_in);
      if (line_in !== 1'b0) return;
      repeat (div / 2) @(posedge clock_in);
      for (int i = 0; i < 8; i++) begin
        repeat (div) @(posedge clock_in);
        v[i] = line_in;
      end
      repeat (div) @(posedge clock_in);
      rxq.push_back(v);
    end
  endtask
endmodule

// ---- verif/test_mbs_slave.sv ----
// Testbench of the serial slave readout
module test_mbs_slave;
  timeunit 1ns;
  timeprecision 1ns;
  import mbs_pkg::*;
  localparam int unsigned HZ = 1_000_000;
  localparam int BASE [6] = '{0, 6, 12, 18, 24, 36};
  logic clock_in, nrst_in, rx_in, tx_out, de_out, cfg_custom_in, cfg_ascii_in;
  logic [7:0] cfg_addr_in, cfg_delay_ms_in;
  logic [2:0] cfg_baud_sel_in;
  logic [1:0] cfg_parity_in;
  logic [3:0] cfg_ifs_chars_in;
  logic [6:0] serial_digits_in;
  logic [31:0] ch [6] = '{32'h3f81_2c4d, 32'h4120_5a6b, 32'h0001_e240, 32'h0000_0d05, 32'h41c8_9e17, 32'h41b4_7c33};
  int err_count, checks;
  mbs_slave #(.CLK_HZ(HZ)) dut_u (.clock_in, .nrst_in, .rx_in, .tx_out, .de_out, .cfg_custom_in, .cfg_addr_in,
    .cfg_baud_sel_in, .cfg_parity_in, .cfg_ascii_in, .cfg_delay_ms_in, .cfg_ifs_chars_in, .serial_digits_in,
    .velocity_value_in(ch[0]), .flow_value_in(ch[1]), .forward_total_in(ch[2]), .reverse_total_in(ch[3]),
    .medium_temperature_value_in(ch[4]), .ambient_temperature_value_in(ch[5]));
  mbs_master_model master_u (.clock_in, .line_in(tx_out), .line_out(rx_in));
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Master keeps frame spacing after the driver drops
  task automatic wait_idle;
    for (int i = 0; i < 60000 && de_out !== 1'b0; i++)
      @(posedge clock_in);
    repeat (44 * master_u.div) @(posedge clock_in);
  endtask
  task automatic ask(input logic [7:0] req[$], input logic [7:0] exp[$]);
    logic [15:0] c;
    wait_idle();
    c = master_u.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    master_u.send(req, 1'b0);
    master_u.recv(exp.size());
    chk_val(master_u.rxq.size(), exp.size());
    foreach (exp[i]) chk_val(master_u.rxq[i], exp[i]);
  endtask
  task automatic hush(input logic [7:0] req[$], input bit bad);
    bit seen;
    wait_idle();
    master_u.send(req, bad);
    seen = 1'b0;
    repeat (105 * master_u.div + 2200) begin
      @(posedge clock_in);
      seen = seen | (de_out !== 1'b0);
    end
    chk_val({31'h0, seen}, 32'h0);
  endtask
  task automatic t_default_read;
    ask('{8'h2a, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02},
      '{8'h2a, 8'h03, 8'h04, ch[0][15:8], ch[0][7:0], ch[0][31:24], ch[0][23:16]});
    chk_val(master_u.be32(master_u.rxq[3], master_u.rxq[4], master_u.rxq[5], master_u.rxq[6], 0), ch[0]);
    chk_val(master_u.be32(master_u.rxq[3], master_u.rxq[4], master_u.rxq[5], master_u.rxq[6], 1),
      {ch[0][7:0], ch[0][15:8], ch[0][23:16], ch[0][31:24]});
  endtask
  task automatic t_refused;
    hush('{8'h2b, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
    hush('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
    hush('{8'h2a, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b1);
  endtask
  task automatic t_custom_map;
    logic [7:0] e[$];
    logic [31:0] w;
    @(posedge clock_in);
    cfg_custom_in <= 1'b1;
    master_u.div = HZ / 57600;
    e = '{8'hfb, 8'h03, 8'h4c};
    for (int r = 0; r < 38; r++) begin
      w = 32'h0;
      for (int k = 0; k < 6; k++) begin
        if (r == BASE[k]) w = ch[k];
        if (r == BASE[k] + 1) w = ch[k] >> 16;
      end
      e.push_back(w[15:8]);
      e.push_back(w[7:0]);
    end
    ask('{8'hfb, 8'h03, 8'h00, 8'h00, 8'h00, 8'h26}, e);
    ask('{8'hfb, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, '{8'hfb, 8'h84, 8'h01});
    // Out of range address falls back to serial digits
    cfg_addr_in <= 8'hfc;
    hush('{8'hfc, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
  endtask
  initial begin
    nrst_in = 1'b0;
    cfg_custom_in = 1'b0;
    cfg_ascii_in = 1'b0;
    cfg_addr_in = 8'hfb;
    cfg_baud_sel_in = 3'h6;
    cfg_parity_in = 2'h0;
    cfg_delay_ms_in = 8'h02;
    cfg_ifs_chars_in = 4'h4;
    serial_digits_in = 7'h2a;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_default_read();
    t_refused();
    t_custom_map();
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clock_in);
    err_count++;
    tally_and_finish();
  end
endmodule
